// ---- common/bre_pkg.sv ----
// Shared constants, types and decode helpers of the boolean rung evaluator.
// Assumes one scan clock; all users import the whole package.
package bre_pkg;

  // ****************************************
  // Sizes and limits
  // ****************************************
  localparam int STK_DEPTH  = 8;
  localparam int DEPTH_W    = 4;
  localparam int WORD_W     = 16;
  localparam int BIT_W      = 4;
  localparam int MEM_ADDR_W = 16;
  localparam int IMG_ADDR_W = 11;

  // Highest point of each image space
  localparam logic [IMG_ADDR_W-1:0] IO_MAX    = 11'h1ff; // Octal 777
  localparam logic [IMG_ADDR_W-1:0] RELAY_MAX = 11'h3ff; // Octal 1777
  localparam logic [IMG_ADDR_W-1:0] TIMER_MAX = 11'h0ff; // Octal 377
  localparam logic [IMG_ADDR_W-1:0] TALLY_MAX = 11'h07f; // Octal 177

  // Value of the stack depth after reset
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 4'h0;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [3:0] {
    OP_OPEN_START, OP_CLOSED_START, OP_BIT_START, OP_INV_BIT_START,
    OP_PAR, OP_PAR_INV, OP_PAR_BIT, OP_PAR_INV_BIT,
    OP_SER, OP_SER_INV, OP_SER_BIT, OP_SER_INV_BIT,
    OP_SER_MERGE, OP_PAR_MERGE, OP_RUNG_CLEAR
  } bre_op_type;

  typedef enum logic [2:0] {
    SPC_INPUT, SPC_OUTPUT, SPC_RELAY, SPC_STAGE, SPC_TIMER, SPC_TALLY, SPC_FLAG
  } bre_space_type;

  typedef enum logic [2:0] {
    STK_NONE, STK_PUSH, STK_AND, STK_OR, STK_MERGE_AND, STK_MERGE_OR, STK_CLEAR
  } bre_stk_cmd_type;

  typedef enum logic [2:0] {
    GRP_START, GRP_PAR, GRP_SER, GRP_MERGE_AND, GRP_MERGE_OR, GRP_CLEAR
  } bre_grp_type;

  typedef struct packed {
    bre_grp_type grp;
    logic        bit_op;
    logic        inv;
  } bre_dec_type;

  // ****************************************
  // Helpers
  // ****************************************
  // Splits an opcode into group, word-bit operand and inversion
  function automatic bre_dec_type bre_decode(input bre_op_type op);
    bre_dec_type d;
    d = '{GRP_CLEAR, 1'b0, 1'b0};
    case (op)
      OP_OPEN_START:    d = '{GRP_START, 1'b0, 1'b0};
      OP_CLOSED_START:  d = '{GRP_START, 1'b0, 1'b1};
      OP_BIT_START:     d = '{GRP_START, 1'b1, 1'b0};
      OP_INV_BIT_START: d = '{GRP_START, 1'b1, 1'b1};
      OP_PAR:           d = '{GRP_PAR, 1'b0, 1'b0};
      OP_PAR_INV:       d = '{GRP_PAR, 1'b0, 1'b1};
      OP_PAR_BIT:       d = '{GRP_PAR, 1'b1, 1'b0};
      OP_PAR_INV_BIT:   d = '{GRP_PAR, 1'b1, 1'b1};
      OP_SER:           d = '{GRP_SER, 1'b0, 1'b0};
      OP_SER_INV:       d = '{GRP_SER, 1'b0, 1'b1};
      OP_SER_BIT:       d = '{GRP_SER, 1'b1, 1'b0};
      OP_SER_INV_BIT:   d = '{GRP_SER, 1'b1, 1'b1};
      OP_SER_MERGE:     d = '{GRP_MERGE_AND, 1'b0, 1'b0};
      OP_PAR_MERGE:     d = '{GRP_MERGE_OR, 1'b0, 1'b0};
      default:          d = '{GRP_CLEAR, 1'b0, 1'b0};
    endcase
    return d;
  endfunction

  // Highest legal point number of an image space
  function automatic logic [IMG_ADDR_W-1:0] bre_space_max(input bre_space_type s);
    logic [IMG_ADDR_W-1:0] m;
    m = IO_MAX;
    case (s)
      SPC_RELAY, SPC_STAGE: m = RELAY_MAX;
      SPC_TIMER:            m = TIMER_MAX;
      SPC_TALLY:            m = TALLY_MAX;
      default:              m = IO_MAX;
    endcase
    return m;
  endfunction

endpackage

// ---- common/bre_stk_if.sv ----
// Carrier between the rung sequencer and the boolean stack.
// Assumes both ends run on the same scan clock.
interface bre_stk_if;
  import bre_pkg::*;

  bre_stk_cmd_type      cmd;
  logic                 val;
  logic                 top;
  logic [DEPTH_W-1:0]   depth;

  modport ctl (output cmd, output val, input top, input depth);
  modport stk (input cmd, input val, output top, output depth);
endinterface

// ---- rtl/bre_stack.sv ----
// Boolean stack of branch values with push, combine and merge commands.
// Assumes the controller never issues a command the depth cannot serve.
module bre_stack
  import bre_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  bre_stk_if.stk    stk
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DEPTH-1:0]   lvl;
    logic [DEPTH_W-1:0] depth;
  } bre_stk_state_type;

  bre_stk_state_type q;
  bre_stk_state_type n;

  initial begin
    if (DEPTH < 2 || DEPTH > 15) begin
      $error("bre_stack: DEPTH must lie in 2..15");
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = q;
    case (stk.cmd)
      STK_PUSH: begin
        n.lvl   = {q.lvl[DEPTH-2:0], stk.val};
        n.depth = q.depth + 4'h1;
      end
      STK_AND: n.lvl[0] = q.lvl[0] & stk.val;
      STK_OR:  n.lvl[0] = q.lvl[0] | stk.val;
      STK_MERGE_AND: begin
        n.lvl    = {1'b0, q.lvl[DEPTH-1:1]};
        n.lvl[0] = q.lvl[0] & q.lvl[1];
        n.depth  = q.depth - 4'h1;
      end
      STK_MERGE_OR: begin
        n.lvl    = {1'b0, q.lvl[DEPTH-1:1]};
        n.lvl[0] = q.lvl[0] | q.lvl[1];
        n.depth  = q.depth - 4'h1;
      end
      STK_CLEAR: begin
        n.lvl   = '0;
        n.depth = DEPTH_RST;
      end
      default: n = q;
    endcase
  end

  // Registers the whole stack
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign stk.top   = q.lvl[0];
  assign stk.depth = q.depth;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  push_shift_a: assert property (
    stk.cmd == STK_PUSH |=> q.lvl[0] == $past(stk.val) && q.lvl[1] == $past(q.lvl[0])
      && q.depth == $past(q.depth) + 4'h1)
    else $error("push did not shift the stack");

  merge_and_a: assert property (
    stk.cmd == STK_MERGE_AND |=> q.lvl[0] == ($past(q.lvl[0]) & $past(q.lvl[1])))
    else $error("series merge value wrong");

  merge_or_a: assert property (
    stk.cmd == STK_MERGE_OR |=> q.lvl[0] == ($past(q.lvl[0]) | $past(q.lvl[1])))
    else $error("parallel merge value wrong");

  merge_depth_a: assert property (
    (stk.cmd == STK_MERGE_AND || stk.cmd == STK_MERGE_OR) |=>
      q.depth == $past(q.depth) - 4'h1 && q.lvl[1] == $past(q.lvl[2]))
    else $error("merge did not drop one level");

endmodule

// ---- rtl/bre_rung_eval.sv ----
// Boolean rung evaluator: sequences contact instructions, fetches operands
// and drives the boolean stack.
// Assumes an external image/word store answering each read with an ack.
//
// Contract
// - An open-contact start pushes a new branch equal to the addressed image point.
// - A closed-contact start pushes the complement of the addressed point.
// - A bit-contact start pushes one bit 0..15 of a word, addressed directly or via pointer.
// - An inverted bit-contact start pushes the complement of the selected word bit.
// - A parallel contact ORs the top branch with the addressed point.
// - An inverted parallel contact ORs the top branch with the point's complement.
// - A parallel bit contact ORs the top branch with the selected word bit.
// - An inverted parallel bit contact ORs the top with the complemented word bit.
// - A series contact ANDs the top branch with the addressed point.
// - An inverted series contact ANDs the top branch with the point's complement.
// - A series bit contact ANDs the top branch with the selected word bit.
// - An inverted series bit contact ANDs the top with the complemented word bit.
// - A series branch merge ANDs the newest branch with the one opened before it.
// - A parallel branch merge ORs the newest branch with the one opened before it.
// - Branches sit on an eight-level stack where each start pushes and shifts down.
// - Branch merges combine the top two levels and lower the depth by one.
module bre_rung_eval
  import bre_pkg::*;
#(
  parameter int STACK_DEPTH = STK_DEPTH
) (
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_instr_valid,
  input  wire bre_pkg::bre_op_type            i_instr_op,
  input  wire bre_pkg::bre_space_type         i_instr_space,
  input  wire logic [bre_pkg::MEM_ADDR_W-1:0] i_instr_addr,
  input  wire logic [bre_pkg::BIT_W-1:0]      i_instr_bit,
  input  wire logic                           i_instr_indirect,
  output logic                                o_busy,
  output logic                                o_rd_req,
  output logic                                o_rd_word,
  output bre_pkg::bre_space_type              o_rd_space,
  output logic [bre_pkg::MEM_ADDR_W-1:0]      o_rd_addr,
  input  wire logic                           i_rd_ack,
  input  wire logic                           i_rd_bit,
  input  wire logic [bre_pkg::WORD_W-1:0]     i_rd_data,
  output logic                                o_done,
  output logic                                o_error,
  output logic                                o_result,
  output logic [bre_pkg::DEPTH_W-1:0]         o_depth
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_READ, ST_APPLY} bre_state_type;

  typedef struct packed {
    bre_state_type          st;
    bre_grp_type            grp;
    logic                   bit_op;
    logic                   inv;
    logic [BIT_W-1:0]       bsel;
    bre_stk_cmd_type        cmd;
    logic                   val;
    logic                   busy;
    logic                   rd_req;
    logic                   rd_word;
    bre_space_type          rd_space;
    logic [MEM_ADDR_W-1:0]  rd_addr;
    logic                   err;
    logic                   err_out;
    logic                   done;
  } bre_ctl_type;

  localparam logic [DEPTH_W-1:0] FULL_DEPTH = DEPTH_W'(STACK_DEPTH);
  localparam logic [DEPTH_W-1:0] ONE_LEVEL  = 4'h1;
  localparam logic [DEPTH_W-1:0] TWO_LEVELS = 4'h2;

  bre_ctl_type     q;
  bre_ctl_type     n;
  bre_dec_type     dec;
  logic            take;
  logic            sel_bit;
  logic            operand;

  bre_stk_if stk_bus ();

  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 15) begin
      $error("bre_rung_eval: STACK_DEPTH must lie in 2..15");
    end
    if (MEM_ADDR_W != WORD_W) begin
      $error("bre_rung_eval: pointer words must hold a full address");
    end
  end

  // ****************************************
  // Operand selection
  // ****************************************
  // Instruction taken only while idle; word bit or image point as operand
  assign take    = (q.st == ST_IDLE) && i_instr_valid;
  assign dec     = bre_decode(i_instr_op);
  assign sel_bit = i_rd_data[q.bsel];
  assign operand = q.bit_op ? sel_bit : i_rd_bit;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    n        = q;
    n.rd_req = 1'b0;
    n.done   = 1'b0;
    n.cmd    = STK_NONE;
    case (q.st)
      ST_IDLE: begin
        if (take) begin
          n.busy   = 1'b1;
          n.grp    = dec.grp;
          n.bit_op = dec.bit_op;
          n.inv    = dec.inv;
          n.bsel   = i_instr_bit;
          n.err    = 1'b0;
          n.st     = ST_APPLY;
          case (dec.grp)
            GRP_START: n.err = (stk_bus.depth >= FULL_DEPTH);
            GRP_PAR, GRP_SER: n.err = (stk_bus.depth < ONE_LEVEL);
            GRP_MERGE_AND: begin
              n.err = (stk_bus.depth < TWO_LEVELS);
              n.cmd = n.err ? STK_NONE : STK_MERGE_AND;
            end
            GRP_MERGE_OR: begin
              n.err = (stk_bus.depth < TWO_LEVELS);
              n.cmd = n.err ? STK_NONE : STK_MERGE_OR;
            end
            GRP_CLEAR: n.cmd = STK_CLEAR;
            default: n.err = 1'b1;
          endcase
          if (!n.err && (dec.grp == GRP_START || dec.grp == GRP_PAR ||
                         dec.grp == GRP_SER)) begin
            // word fetch for bit contacts, via pointer when indirect; otherwise a range-checked point read
            if (dec.bit_op) begin
              n.rd_addr = i_instr_addr;
              n.rd_word = 1'b1;
              n.rd_req  = 1'b1;
              n.st      = i_instr_indirect ? ST_PTR : ST_READ;
            end else if (i_instr_addr > MEM_ADDR_W'(bre_space_max(i_instr_space))) begin
              n.err = 1'b1;
            end else begin
              n.rd_space = i_instr_space;
              n.rd_addr  = i_instr_addr;
              n.rd_word  = 1'b0;
              n.rd_req  = 1'b1;
              n.st      = ST_READ;
            end
          end
        end
      end
      ST_PTR: begin
        // Pointer word names the word that holds the bit
        if (i_rd_ack) begin
          n.rd_addr = i_rd_data;
          n.rd_req  = 1'b1;
          n.st      = ST_READ;
        end
      end
      ST_READ: begin
        if (i_rd_ack) begin
          n.val = operand ^ q.inv;
          n.st  = ST_APPLY;
          case (q.grp)
            GRP_START: n.cmd = STK_PUSH;
            GRP_PAR:   n.cmd = STK_OR;
            GRP_SER:   n.cmd = STK_AND;
            default:   n.cmd = STK_NONE;
          endcase
        end
      end
      ST_APPLY: begin
        // Stack updates on this edge, result shows with done
        n.done    = 1'b1;
        n.err_out = q.err;
        n.busy    = 1'b0;
        n.st      = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    if (q.st != ST_APPLY) begin
      n.err_out = 1'b0;
    end
  end

  // Registers the sequencer state
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Stack and outputs
  // ****************************************
  assign stk_bus.cmd = q.cmd;
  assign stk_bus.val = q.val;

  bre_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .stk       (stk_bus.stk)
  );

  // All driven straight from flops
  assign o_busy     = q.busy;
  assign o_rd_req   = q.rd_req;
  assign o_rd_word  = q.rd_word;
  assign o_rd_space = q.rd_space;
  assign o_rd_addr  = q.rd_addr;
  assign o_done     = q.done;
  assign o_error    = q.err_out;
  assign o_result   = stk_bus.top;
  assign o_depth    = stk_bus.depth;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  open_start_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_START && !q.bit_op && !q.inv
      |=> q.cmd == STK_PUSH && q.val == $past(i_rd_bit) ##1 o_done && o_result == $past(q.val))
    else $error("open start did not push the point");

  closed_start_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_START && !q.bit_op && q.inv
      |=> q.cmd == STK_PUSH && q.val == !$past(i_rd_bit))
    else $error("closed start did not push the complement");

  bit_start_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_START && q.bit_op && !q.inv
      |=> q.cmd == STK_PUSH && q.val == $past(sel_bit))
    else $error("bit start pushed the wrong bit");

  inv_bit_start_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_START && q.bit_op && q.inv
      |=> q.cmd == STK_PUSH && q.val == !$past(sel_bit))
    else $error("inverted bit start wrong");

  parallel_or_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_PAR
      |=> q.cmd == STK_OR && q.val == ($past(operand) ^ $past(q.inv)))
    else $error("parallel contact not ORed");

  series_and_a: assert property (
    q.st == ST_READ && i_rd_ack && q.grp == GRP_SER
      |=> q.cmd == STK_AND && q.val == ($past(operand) ^ $past(q.inv)))
    else $error("series contact not ANDed");

  merge_issue_a: assert property (
    take && (dec.grp == GRP_MERGE_AND || dec.grp == GRP_MERGE_OR) && stk_bus.depth >= TWO_LEVELS
      |-> ##2 o_done && !o_error && o_depth == $past(stk_bus.depth, 2) - 4'h1)
    else $error("merge did not complete");

  full_stack_a: assert property (
    take && dec.grp == GRP_START && stk_bus.depth >= FULL_DEPTH
      |=> !o_rd_req ##1 o_done && o_error && o_depth == FULL_DEPTH)
    else $error("overflow not flagged");

  short_merge_a: assert property (
    take && (dec.grp == GRP_MERGE_AND || dec.grp == GRP_MERGE_OR) && stk_bus.depth < TWO_LEVELS
      |=> !o_rd_req ##1 o_done && o_error)
    else $error("underflow not flagged");

  empty_combine_a: assert property (
    take && (dec.grp == GRP_PAR || dec.grp == GRP_SER) && stk_bus.depth < ONE_LEVEL
      |=> !o_rd_req ##1 o_done && o_error)
    else $error("combine on empty stack not flagged");

  point_range_a: assert property (
    take && !dec.bit_op && (dec.grp == GRP_START || dec.grp == GRP_PAR || dec.grp == GRP_SER)
      && i_instr_addr > MEM_ADDR_W'(bre_space_max(i_instr_space)) |=> !o_rd_req ##1 o_error)
    else $error("point outside its space not refused");

  refused_hold_a: assert property (
    o_done && o_error |-> o_depth == $past(o_depth, 2) && o_result == $past(o_result, 2))
    else $error("refused instruction changed the stack");

  stack_push_a: assert property (
    q.cmd == STK_PUSH && stk_bus.depth < FULL_DEPTH |=> o_depth == $past(stk_bus.depth) + 4'h1)
    else $error("push did not deepen the stack");

  pointer_fetch_a: assert property (
    q.st == ST_PTR && i_rd_ack |=> o_rd_req && o_rd_word && o_rd_addr == $past(i_rd_data))
    else $error("pointer word not followed");

endmodule

// ---- bench/test_bre_rung_eval.sv ----
// Self-checking testbench of the boolean rung evaluator top module.
// Assumes bre_pkg and the design files are compiled first; one scan clock.
module test_bre_rung_eval;
  timeunit 1ns;
  timeprecision 1ps;
  import bre_pkg::*;

  // ****************************************
  // Signals and reference state
  // ****************************************
  logic                  ref_clk, rst_n, in_valid, in_ind, rd_ack, rd_bit, ans_bit;
  bre_op_type            in_op;
  bre_space_type         in_sp, rd_space;
  logic [MEM_ADDR_W-1:0] in_addr, rd_addr;
  logic [BIT_W-1:0]      in_bit;
  logic [WORD_W-1:0]     rd_data, ans_word;
  logic                  busy, rd_req, rd_word, done, error, result;
  logic [DEPTH_W-1:0]    depth;
  logic [7:0]            stk;
  logic [19:0]           rd_q[$];
  int                    n_fail, checks, ack_dly, pend, exp_d;

  bre_rung_eval #(.STACK_DEPTH(8)) u_dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_instr_valid(in_valid), .i_instr_op(in_op),
    .i_instr_space(in_sp), .i_instr_addr(in_addr), .i_instr_bit(in_bit),
    .i_instr_indirect(in_ind), .o_busy(busy), .o_rd_req(rd_req), .o_rd_word(rd_word),
    .o_rd_space(rd_space), .o_rd_addr(rd_addr), .i_rd_ack(rd_ack), .i_rd_bit(rd_bit),
    .i_rd_data(rd_data), .o_done(done), .o_error(error), .o_result(result), .o_depth(depth)
  );

  // Scan clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  // ****************************************
  // Store contents and helpers
  // ****************************************
  function automatic logic pt(input bre_space_type s, input logic [15:0] a);
    return ^{a, s};
  endfunction

  function automatic logic [15:0] wd(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5a3c;
  endfunction

  function automatic logic [15:0] lim(input bre_space_type s);
    case (s)
      SPC_RELAY, SPC_STAGE: return 16'h03ff;
      SPC_TIMER:            return 16'h00ff;
      SPC_TALLY:            return 16'h007f;
      default:              return 16'h01ff;
    endcase
  endfunction

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_vec(input string nm, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Store side: checks each request against the expected queue, notes the answer
  always @(negedge ref_clk) begin
    if (rd_req === 1'b1) begin
      if (rd_q.size() == 0) begin
        cmp_bit("rd_req", 1'b0, rd_req);
      end else begin
        cmp_vec("rd_word", {19'h0, rd_q[0][19]}, {19'h0, rd_word});
        cmp_vec("rd_addr", {4'h0, rd_q[0][15:0]}, {4'h0, rd_addr});
        if (!rd_q[0][19]) cmp_vec("rd_space", {17'h0, rd_q[0][18:16]}, {17'h0, rd_space});
        void'(rd_q.pop_front());
      end
      pend = ack_dly + 1;
      ans_bit = pt(rd_space, rd_addr);
      ans_word = wd(rd_addr);
    end
  end

  // Store side: one-cycle answer, data lines scrambled while not answering
  always @(posedge ref_clk) begin
    if (pend == 1) begin
      rd_ack  <= 1'b1;
      rd_bit  <= ans_bit;
      rd_data <= ans_word;
    end else begin
      rd_ack  <= 1'b0;
      rd_bit  <= ~rd_bit;
      rd_data <= ~rd_data;
    end
    if (pend > 0) pend = pend - 1;
  end

  // ****************************************
  // One instruction with reference model
  // ****************************************
  task automatic run(input bre_op_type op, input bre_space_type sp, input logic [15:0] a,
                     input logic [3:0] b, input logic ind);
    logic        v, e, m;
    logic [15:0] wa, ww;
    int          g, k;
    g = int'(op) >> 2;
    wa = ind ? wd(a) : a;
    ww = wd(wa);
    v = (op[1] ? ww[b] : pt(sp, a)) ^ op[0];
    if (op == OP_RUNG_CLEAR) e = 1'b0;
    else if (g == 3) e = (exp_d < 2);
    else e = (g == 0 ? exp_d == 8 : exp_d == 0) || (!op[1] && a > lim(sp));
    if (!e && g < 3) begin
      if (op[1] && ind) rd_q.push_back({1'b1, 3'h0, a});
      if (op[1]) rd_q.push_back({1'b1, 3'h0, wa});
      else rd_q.push_back({1'b0, sp, a});
    end
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_op    <= op;
    in_sp    <= sp;
    in_addr  <= a;
    in_bit   <= b;
    in_ind   <= ind;
    @(posedge ref_clk);
    in_valid <= 1'b0;
    @(negedge ref_clk);
    cmp_bit("busy", 1'b1, busy);
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 40) begin
      cmp_bit("done", 1'b1, done);
      end_of_test();
    end
    if (!e) begin
      m = (op == OP_SER_MERGE) ? (stk[0] & stk[1]) : (stk[0] | stk[1]);
      if (op == OP_RUNG_CLEAR) begin
        exp_d = 0;
        stk   = 8'h0;
      end else if (g == 0) begin
        stk   = {stk[6:0], v};
        exp_d++;
      end else if (g == 1) begin
        stk[0] = stk[0] | v;
      end else if (g == 2) begin
        stk[0] = stk[0] & v;
      end else begin
        stk   = {1'b0, stk[7:2], m};
        exp_d--;
      end
    end
    // Every expected read must have been issued by now
    cmp_vec("rd_q", 20'h0, 20'(rd_q.size()));
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("error", e, error);
    cmp_vec("depth", 20'(exp_d), {16'h0, depth});
    if (exp_d > 0) cmp_bit("result", stk[0], result);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_starts;
    for (int s = 0; s < 7; s++) begin
      run(OP_OPEN_START, bre_space_type'(s), lim(bre_space_type'(s)), 4'h0, 1'b0);
      run(OP_CLOSED_START, bre_space_type'(s), lim(bre_space_type'(s)) + 16'h1, 4'h0, 1'b0);
      run(OP_CLOSED_START, bre_space_type'(s), 16'(s * 3), 4'h0, 1'b0);
      run(OP_RUNG_CLEAR, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    end
  endtask

  task automatic t_bits;
    for (int b = 0; b < 16; b++) begin
      run(OP_BIT_START, SPC_INPUT, 16'h0140 + 16'(b), 4'(b), b[0]);
      run(OP_INV_BIT_START, SPC_INPUT, 16'h1400, 4'(15 - b), b[1]);
      run(OP_RUNG_CLEAR, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    end
  endtask

  task automatic t_combine;
    run(OP_PAR, SPC_INPUT, 16'h0001, 4'h0, 1'b0);
    for (int o = 4; o < 12; o++) begin
      for (int t = 0; t < 4; t++) begin
        run(OP_OPEN_START, SPC_INPUT, 16'(t[0]), 4'h0, 1'b0);
        run(bre_op_type'(o), bre_space_type'(o % 4), 16'h0100 + 16'(t), 4'(o + t), t[1]);
        run(OP_RUNG_CLEAR, SPC_INPUT, 16'h0, 4'h0, 1'b0);
      end
    end
  endtask

  task automatic t_merge;
    ack_dly = 3;
    for (int i = 0; i < 9; i++) run(OP_OPEN_START, SPC_RELAY, 16'(i * 5), 4'h0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      run(i[0] ? OP_PAR_MERGE : OP_SER_MERGE, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    end
    run(OP_PAR_MERGE, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    run(OP_OPEN_START, SPC_INPUT, 16'h0001, 4'h0, 1'b0);
    run(OP_OPEN_START, SPC_INPUT, 16'h0000, 4'h0, 1'b0);
    run(OP_PAR_MERGE, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    run(OP_RUNG_CLEAR, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    run(OP_SER_MERGE, SPC_INPUT, 16'h0, 4'h0, 1'b0);
    ack_dly = 0;
  endtask

  task automatic t_mid_reset;
    run(OP_OPEN_START, SPC_INPUT, 16'h0001, 4'h0, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    exp_d = 0;
    @(negedge ref_clk);
    cmp_vec("depth", 20'h0, {16'h0, depth});
    cmp_bit("result", 1'b0, result);
    run(OP_CLOSED_START, SPC_TIMER, 16'h00ff, 4'h0, 1'b0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_op = OP_OPEN_START;
    in_sp = SPC_INPUT;
    in_addr = 16'h0;
    in_bit = 4'h0;
    in_ind = 1'b0;
    rd_ack = 1'b0;
    rd_bit = 1'b0;
    rd_data = 16'h0;
    n_fail = 0;
    checks = 0;
    ack_dly = 0;
    pend = 0;
    stk = 8'h0;
    exp_d = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    cmp_vec("depth", 20'h0, {16'h0, depth});
    cmp_bit("done", 1'b0, done);
    t_starts();
    t_bits();
    t_combine();
    t_merge();
    t_mid_reset();
    end_of_test();
  end
endmodule
